// >>> rtl/octal_event_counter_bank.sv
// Top of the eight-lane event counter bank with APB register slave and run line.
// Assumes pins are asynchronous and an external pull-up holds the run line high.
`timescale 1ns/10ps
`default_nettype none
module octal_event_counter_bank (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  count_in,
   input  wire logic [7:0]  gate_in,
   input  wire logic        common_gate_in,
   input  wire logic        load_in,
   input  wire logic        run_in,
   output logic             run_out,
   output logic             run_oe,
   output logic      [1:0]  carry_out,
   output logic             irq
);

   localparam int unsigned N = event_bank_pkg::NUM_CNT;

   event_bank_pkg::pin_bundle_t  raw;
   event_bank_pkg::pin_bundle_t  syn;
   event_bank_pkg::counter_cfg_t cfg_ff     [N];
   event_bank_pkg::counter_cfg_t nxt_cfg    [N];
   logic [31:0]                  start_ff   [N];
   logic [31:0]                  nxt_start  [N];
   logic [N-1:0][31:0]           snap_ff;
   logic [N-1:0][31:0]           nxt_snap;
   logic [N-1:0][31:0]           cnt_val;
   logic [N-1:0]                 carry_vec;
   logic [N-1:0]                 term_vec;
   logic [N-1:0]                 lane_cin;
   logic [N-1:0]                 lane_load;
   logic [N-1:0]                 preset_vec;
   logic [N-1:0]                 load_sw;
   logic [2:0]                   ctrl_ff;
   logic [2:0]                   nxt_ctrl;
   logic [8:0]                   stat_ff;
   logic [8:0]                   nxt_stat;
   logic [8:0]                   mask_ff;
   logic [8:0]                   nxt_mask;
   logic [8:0]                   ev;
   logic                         armed_ff;
   logic                         nxt_armed;
   logic                         load_prev_ff;
   logic                         run_oe_ff;
   logic                         nxt_run_oe;
   logic                         irq_ff;
   logic                         nxt_irq;
   logic [31:0]                  prdata_ff;
   logic [31:0]                  nxt_prdata;
   logic                         err_ff;
   logic                         nxt_err;
   logic                         setup;
   logic                         wr;
   logic                         snap_take;
   logic                         ext_load;
   logic                         preset_hit;
   logic                         watch_low;
   logic                         stop_cmd;
   logic                         halt_ev;
   logic                         mapped;
   logic [2:0]                   idx;

   // Word at a fixed offset
   function automatic logic word_hit(input logic [31:0] a, input logic [7:0] off);
      return a == {24'h000000, off};
   endfunction

   // Word inside an eight-word bank aligned to 32 bytes
   function automatic logic bank_hit(input logic [31:0] a, input logic [7:0] base);
      return (a[31:5] == {24'h000000, base[7:5]}) && (a[1:0] == 2'h0);
   endfunction

   assign raw = {run_in, load_in, common_gate_in, gate_in, count_in};

   sync2 #(
      .WIDTH ($bits(event_bank_pkg::pin_bundle_t))
   ) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (raw),
      .q       (syn)
   );

   // Count source per lane, carries allow chaining
   always_comb
   begin
      for (int i = 0; i < N; i++)
      begin
         unique case (cfg_ff[i].src)
            event_bank_pkg::SRC_CARRY0: lane_cin[i] = carry_vec[0];
            event_bank_pkg::SRC_CARRY1: lane_cin[i] = carry_vec[1];
            default:                    lane_cin[i] = syn.cnt[i];
         endcase
         preset_vec[i] = cfg_ff[i].preset;
         lane_load[i]  = (ext_load & cfg_ff[i].load_en) | load_sw[i];
      end
   end

   for (genvar g = 0; g < N; g++)
   begin : g_lane
      event_counter_lane #(
         .UPDOWN_CAP ((g == event_bank_pkg::UPDOWN_LO) || (g == event_bank_pkg::UPDOWN_HI))
      ) u_lane (
         .pclk        (pclk),
         .presetn     (presetn),
         .cfg         (cfg_ff[g]),
         .cin         (lane_cin[g]),
         .common_gate (syn.common),
         .ind_gate    (syn.gate[g]),
         .run_high    (syn.run),
         .armed       (armed_ff),
         .load        (lane_load[g]),
         .start_val   (start_ff[g]),
         .count       (cnt_val[g]),
         .carry       (carry_vec[g]),
         .term_hit    (term_vec[g])
      );
   end

   always_comb
   begin
      setup      = psel & ~penable;
      wr         = psel & penable & pwrite;
      idx        = paddr[4:2];
      mapped     = word_hit(paddr, event_bank_pkg::OFF_CTRL)
                 | word_hit(paddr, event_bank_pkg::OFF_STATUS)
                 | word_hit(paddr, event_bank_pkg::OFF_IRQ_STAT)
                 | word_hit(paddr, event_bank_pkg::OFF_IRQ_MASK)
                 | word_hit(paddr, event_bank_pkg::OFF_CMD)
                 | word_hit(paddr, event_bank_pkg::OFF_LOADCMD)
                 | bank_hit(paddr, event_bank_pkg::OFF_CFG)
                 | bank_hit(paddr, event_bank_pkg::OFF_START)
                 | bank_hit(paddr, event_bank_pkg::OFF_COUNT);
      snap_take  = setup & ~pwrite & word_hit(paddr, event_bank_pkg::OFF_COUNT);
      load_sw    = (wr && word_hit(paddr, event_bank_pkg::OFF_LOADCMD)) ? pwdata[N-1:0] : '0;
      ext_load   = syn.load & ~load_prev_ff;
      stop_cmd   = wr & word_hit(paddr, event_bank_pkg::OFF_CMD)
                 & pwdata[event_bank_pkg::CMD_STOP];
      preset_hit = |(term_vec & preset_vec);
      watch_low  = ctrl_ff[event_bank_pkg::CTRL_WATCH] & ~syn.run;
      halt_ev    = armed_ff & (preset_hit | watch_low | stop_cmd);
      ev         = {halt_ev, term_vec};

      nxt_ctrl   = ctrl_ff;
      nxt_mask   = mask_ff;
      nxt_armed  = armed_ff;
      nxt_snap   = snap_ff;
      nxt_stat   = stat_ff;
      nxt_prdata = prdata_ff;
      nxt_err    = 1'b0;
      for (int i = 0; i < N; i++)
      begin
         nxt_cfg[i]   = cfg_ff[i];
         nxt_start[i] = start_ff[i];
      end

      if (wr && word_hit(paddr, event_bank_pkg::OFF_CTRL))
      begin
         nxt_ctrl = pwdata[event_bank_pkg::CTRL_W-1:0];
      end
      if (wr && word_hit(paddr, event_bank_pkg::OFF_IRQ_MASK))
      begin
         nxt_mask = pwdata[event_bank_pkg::IRQ_W-1:0];
      end
      if (wr && word_hit(paddr, event_bank_pkg::OFF_IRQ_STAT))
      begin
         nxt_stat = stat_ff & ~pwdata[event_bank_pkg::IRQ_W-1:0];
      end
      nxt_stat = nxt_stat | ev;
      if (wr && bank_hit(paddr, event_bank_pkg::OFF_CFG))
      begin
         nxt_cfg[idx] = pwdata[event_bank_pkg::CFG_W-1:0];
      end
      if (wr && bank_hit(paddr, event_bank_pkg::OFF_START))
      begin
         nxt_start[idx] = pwdata;
      end
      if (wr && word_hit(paddr, event_bank_pkg::OFF_CMD) && pwdata[event_bank_pkg::CMD_ARM])
      begin
         nxt_armed = 1'b1;
      end
      if (halt_ev)
      begin
         nxt_armed = 1'b0;
      end
      if (snap_take)
      begin
         nxt_snap = cnt_val;
      end

      if (setup)
      begin
         nxt_err    = ~mapped;
         nxt_prdata = 32'h00000000;
         if (!pwrite)
         begin
            if (word_hit(paddr, event_bank_pkg::OFF_CTRL))
            begin
               nxt_prdata = {{(32-event_bank_pkg::CTRL_W){1'b0}}, ctrl_ff};
            end
            else if (word_hit(paddr, event_bank_pkg::OFF_STATUS))
            begin
               nxt_prdata = {28'h0000000, carry_vec[1:0], syn.run, armed_ff};
            end
            else if (word_hit(paddr, event_bank_pkg::OFF_IRQ_STAT))
            begin
               nxt_prdata = {{(32-event_bank_pkg::IRQ_W){1'b0}}, stat_ff};
            end
            else if (word_hit(paddr, event_bank_pkg::OFF_IRQ_MASK))
            begin
               nxt_prdata = {{(32-event_bank_pkg::IRQ_W){1'b0}}, mask_ff};
            end
            else if (bank_hit(paddr, event_bank_pkg::OFF_CFG))
            begin
               nxt_prdata = {{(32-event_bank_pkg::CFG_W){1'b0}}, cfg_ff[idx]};
            end
            else if (bank_hit(paddr, event_bank_pkg::OFF_START))
            begin
               nxt_prdata = start_ff[idx];
            end
            else if (bank_hit(paddr, event_bank_pkg::OFF_COUNT))
            begin
               nxt_prdata = (idx == 3'h0) ? cnt_val[0] : snap_ff[idx];
            end
         end
      end

      // Open drain: enable means pull low
      nxt_run_oe = nxt_ctrl[event_bank_pkg::CTRL_FORCE]
                 | (nxt_ctrl[event_bank_pkg::CTRL_DRIVE] & ~nxt_armed);
      nxt_irq    = |(nxt_stat & nxt_mask);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_ff      <= event_bank_pkg::CTRL_RST;
         mask_ff      <= event_bank_pkg::IRQ_RST;
         stat_ff      <= event_bank_pkg::IRQ_RST;
         armed_ff     <= 1'b0;
         load_prev_ff <= 1'b0;
         run_oe_ff    <= 1'b0;
         irq_ff       <= 1'b0;
         prdata_ff    <= 32'h00000000;
         err_ff       <= 1'b0;
         snap_ff      <= '0;
         for (int i = 0; i < N; i++)
         begin
            cfg_ff[i]   <= event_bank_pkg::CFG_RST;
            start_ff[i] <= event_bank_pkg::START_RST;
         end
      end
      else
      begin
         ctrl_ff      <= nxt_ctrl;
         mask_ff      <= nxt_mask;
         stat_ff      <= nxt_stat;
         armed_ff     <= nxt_armed;
         load_prev_ff <= syn.load;
         run_oe_ff    <= nxt_run_oe;
         irq_ff       <= nxt_irq;
         prdata_ff    <= nxt_prdata;
         err_ff       <= nxt_err;
         snap_ff      <= nxt_snap;
         for (int i = 0; i < N; i++)
         begin
            cfg_ff[i]   <= nxt_cfg[i];
            start_ff[i] <= nxt_start[i];
         end
      end
   end

   assign prdata    = prdata_ff;
   assign pready    = 1'b1;
   assign pslverr   = psel & penable & err_ff;
   assign run_out   = 1'b0;
   assign run_oe    = run_oe_ff;
   assign carry_out = carry_vec[event_bank_pkg::CARRY_LANES-1:0];
   assign irq       = irq_ff;

   chk_preset_halts: assert property (
      @(posedge pclk) disable iff (!presetn)
      armed_ff && preset_hit |=> !armed_ff)
      else $error("preset terminal did not halt");

   chk_watch_halts: assert property (
      @(posedge pclk) disable iff (!presetn)
      armed_ff && ctrl_ff[event_bank_pkg::CTRL_WATCH] && !syn.run |=> !armed_ff)
      else $error("low run line did not halt");

   chk_drive_release: assert property (
      @(posedge pclk) disable iff (!presetn)
      armed_ff && !ctrl_ff[event_bank_pkg::CTRL_FORCE] |-> !run_oe)
      else $error("run line pulled while armed");

   chk_drive_pull: assert property (
      @(posedge pclk) disable iff (!presetn)
      $fell(armed_ff) && ctrl_ff[event_bank_pkg::CTRL_DRIVE] |-> run_oe && !run_out)
      else $error("run line not pulled after halt");

   chk_snap_coherent: assert property (
      @(posedge pclk) disable iff (!presetn)
      snap_take |=> snap_ff == $past(cnt_val))
      else $error("snapshot not coherent");

endmodule
`default_nettype wire

// >>> rtl/event_bank_pkg.sv
// Constants, register map and carrier types of the eight-lane event counter bank.
// Assumes an APB master on pclk and a wired-AND run line with an external pull-up.
// Operation
// - Eight 32-bit counters on one 100 MHz clock
// - Per-counter input polarity applied before counting
// - Count chosen input edge, or every clock
// - Counters one, two carry high at terminal
// - Carry output selectable as another counter's input
// - Counters three, four: gate becomes direction
// - Preset terminal count halts the measurement, pulling run line low when drive is set
// - Common and individual gates, usage per counter
// - Run line is open-drain wired-AND, shared
// - Software enables, sets, resets run line usage
// - Watched run line low halts the measurement
// - Drive: release while armed, low when halted
// - External load pulse reloads enabled start values
// - Run line may gate each counter's counting
// - Counter one count read snapshots all counters together
package event_bank_pkg;

   localparam int unsigned NUM_CNT     = 8;
   localparam int unsigned CNT_W       = 32;
   localparam int unsigned CARRY_LANES = 2;
   localparam int unsigned UPDOWN_LO   = 2;
   localparam int unsigned UPDOWN_HI   = 3;

   localparam logic [31:0] TERMINAL  = 32'hffffffff;
   localparam logic [31:0] START_RST = 32'h00000000;

   // Byte offsets on the register bus
   localparam logic [7:0] OFF_CTRL     = 8'h00;
   localparam logic [7:0] OFF_STATUS   = 8'h04;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h0c;
   localparam logic [7:0] OFF_CMD      = 8'h10;
   localparam logic [7:0] OFF_LOADCMD  = 8'h14;
   localparam logic [7:0] OFF_CFG      = 8'h40;
   localparam logic [7:0] OFF_START    = 8'h60;
   localparam logic [7:0] OFF_COUNT    = 8'h80;

   // Control bits
   localparam int unsigned CTRL_WATCH = 0;
   localparam int unsigned CTRL_DRIVE = 1;
   localparam int unsigned CTRL_FORCE = 2;
   localparam int unsigned CTRL_W     = 3;
   localparam logic [2:0]  CTRL_RST   = 3'h0;

   // Command bits
   localparam int unsigned CMD_ARM  = 0;
   localparam int unsigned CMD_STOP = 1;

   // Status bits
   localparam int unsigned ST_ARMED = 0;
   localparam int unsigned ST_RUN   = 1;
   localparam int unsigned ST_CARRY = 2;

   // Interrupt layout: bits 0..7 terminal reached, bit 8 halt
   localparam int unsigned IRQ_HALT = 8;
   localparam int unsigned IRQ_W    = 9;
   localparam logic [8:0]  IRQ_RST  = 9'h000;

   // Count source select
   localparam logic [1:0] SRC_PIN    = 2'h0;
   localparam logic [1:0] SRC_CARRY0 = 2'h1;
   localparam logic [1:0] SRC_CARRY1 = 2'h2;

   typedef struct packed {
      logic [1:0] src;
      logic       run_ctl;
      logic       load_en;
      logic       preset;
      logic       updown;
      logic       use_ind;
      logic       use_common;
      logic       timer;
      logic       falling;
      logic       invert;
   } counter_cfg_t;

   localparam int unsigned  CFG_W   = $bits(counter_cfg_t);
   localparam counter_cfg_t CFG_RST = '0;

   typedef struct packed {
      logic               run;
      logic               load;
      logic               common;
      logic [NUM_CNT-1:0] gate;
      logic [NUM_CNT-1:0] cnt;
   } pin_bundle_t;

endpackage

// >>> rtl/sync2.sv
// Two-flop synchroniser for a bundle of asynchronous pin levels.
// Assumes the inputs are slow levels; no bus coherence is provided.
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] q_ff;

   if (WIDTH < 1)
   begin : g_chk
      $error("sync2 WIDTH must be at least one");
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_ff <= '0;
         q_ff    <= '0;
      end
      else
      begin
         meta_ff <= d;
         q_ff    <= meta_ff;
      end
   end

   assign q = q_ff;

endmodule
`default_nettype wire

// >>> rtl/event_counter_lane.sv
// One 32-bit counter lane: polarity, edge or timer count, gates, direction, load.
// Assumes synchronised inputs on pclk; load has priority over counting.
`timescale 1ns/10ps
`default_nettype none
module event_counter_lane #(
   parameter bit UPDOWN_CAP = 1'b0
) (
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   input  wire event_bank_pkg::counter_cfg_t  cfg,
   input  wire logic                          cin,
   input  wire logic                          common_gate,
   input  wire logic                          ind_gate,
   input  wire logic                          run_high,
   input  wire logic                          armed,
   input  wire logic                          load,
   input  wire logic [31:0]                   start_val,
   output logic      [31:0]                   count,
   output logic                               carry,
   output logic                               term_hit
);

   logic [31:0] count_ff;
   logic [31:0] nxt_count;
   logic        prev_ff;
   logic        nxt_prev;
   logic        carry_ff;
   logic        nxt_carry;
   logic        term_ff;
   logic        nxt_term;
   logic        lvl;
   logic        edge_seen;
   logic        dir_mode;
   logic        up;
   logic        gate_ok;
   logic        cnt_en;

   always_comb
   begin
      lvl       = cin ^ cfg.invert;
      edge_seen = cfg.falling ? (prev_ff & ~lvl) : (~prev_ff & lvl);
      dir_mode  = UPDOWN_CAP & cfg.updown;
      up        = dir_mode ? ind_gate : 1'b1;
      gate_ok   = (~cfg.use_common | common_gate)
                & (dir_mode | ~cfg.use_ind | ind_gate);
      cnt_en    = armed & gate_ok & (~cfg.run_ctl | run_high)
                & (cfg.timer | edge_seen);
      nxt_prev  = lvl;
      nxt_count = count_ff;
      if (load)
      begin
         nxt_count = start_val;
      end
      else if (cnt_en)
      begin
         nxt_count = up ? count_ff + 32'h00000001 : count_ff - 32'h00000001;
      end
      nxt_carry = (nxt_count == event_bank_pkg::TERMINAL);
      nxt_term  = nxt_carry & ~carry_ff;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         count_ff <= event_bank_pkg::START_RST;
         prev_ff  <= 1'b0;
         carry_ff <= 1'b0;
         term_ff  <= 1'b0;
      end
      else
      begin
         count_ff <= nxt_count;
         prev_ff  <= nxt_prev;
         carry_ff <= nxt_carry;
         term_ff  <= nxt_term;
      end
   end

   assign count    = count_ff;
   assign carry    = carry_ff;
   assign term_hit = term_ff;

   chk_carry_at_terminal: assert property (
      @(posedge pclk) disable iff (!presetn)
      carry_ff == (count_ff == event_bank_pkg::TERMINAL))
      else $error("carry does not match terminal count");

   chk_timer_step_up: assert property (
      @(posedge pclk) disable iff (!presetn)
      cfg.timer && cnt_en && up && !load |=> count_ff == $past(count_ff) + 32'h00000001)
      else $error("timer did not advance by one");

   chk_gate_holds: assert property (
      @(posedge pclk) disable iff (!presetn)
      cfg.use_common && !common_gate && !load |=> $stable(count_ff))
      else $error("counter moved while gate inactive");

   chk_down_step: assert property (
      @(posedge pclk) disable iff (!presetn)
      dir_mode && !ind_gate && cnt_en && !load
      |=> count_ff == $past(count_ff) - 32'h00000001)
      else $error("down count did not step by one");

   chk_load_value: assert property (
      @(posedge pclk) disable iff (!presetn)
      load |=> count_ff == $past(start_val))
      else $error("load did not take start value");

endmodule
`default_nettype wire

// >>> sim/pulse_source_model.sv
// Far side of the counter bank: pulse sources, load source, other instruments on the run line.
// Assumes the bench calls its tasks one at a time; signals change on rising pclk edges.
`timescale 1ns/10ps
`default_nettype none
module pulse_source_model (
   input  wire logic       pclk,
   input  wire logic       run_oe,
   input  wire logic       run_out,
   output logic      [7:0] count_in,
   output logic            load_in,
   output wire logic       run_in
);
   logic other_pull = 1'b0;
   // Pull-up on the line; any driver pulling low wins
   assign run_in = ~((run_oe & ~run_out) | other_pull);
   initial
   begin
      count_in = 8'h00;
      load_in  = 1'b0;
   end
   task pulse(input int lane, input int n);
      repeat (n)
      begin
         @(posedge pclk) count_in[lane] <= 1'b1;
         repeat (3) @(posedge pclk);
         count_in[lane] <= 1'b0;
         repeat (3) @(posedge pclk);
      end
   endtask
   task automatic load_pulse;
      @(posedge pclk) load_in <= 1'b1;
      repeat (3) @(posedge pclk);
      load_in <= 1'b0;
   endtask
   // Another instrument halting everyone
   task automatic hold_low(input logic v);
      @(posedge pclk) other_pull <= v;
   endtask
endmodule
`default_nettype wire

// >>> sim/tb.sv
// Self-checking bench of the counter bank: APB master, gates, scenario tasks.
// Assumes pulse_source_model stands for the pins it drives.
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] paddr = 32'h00000000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  count_in;
   logic [7:0]  gate_in = 8'h00;
   logic        common_gate_in = 1'b0;
   logic        load_in;
   wire logic   run_in;
   logic        run_out;
   logic        run_oe;
   logic [1:0]  carry_out;
   logic        irq;
   logic        last_err;
   logic [31:0] rv;
   int          err_total = 0;
   int          check_count = 0;

   octal_event_counter_bank i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .count_in(count_in), .gate_in(gate_in),
      .common_gate_in(common_gate_in), .load_in(load_in), .run_in(run_in),
      .run_out(run_out), .run_oe(run_oe), .carry_out(carry_out), .irq(irq));
   pulse_source_model i_src (.pclk(pclk), .run_oe(run_oe), .run_out(run_out),
      .count_in(count_in), .load_in(load_in), .run_in(run_in));

   initial
   begin
      forever #5 pclk = ~pclk;
   end

   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
         err_total++;
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] off, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= {24'h000000, off};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
         err_total++;
      rv       = prdata;
      last_err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] off, input logic [31:0] d);
      apb(1'b1, off, d);
   endtask

   task automatic chk_reg(input logic [7:0] off, input logic [31:0] exp);
      apb(1'b0, off, 32'h00000000);
      chk(rv, exp);
   endtask

   // Counter read: lane 0 first takes the snapshot
   task automatic chk_cnt(input int lane, input logic [31:0] exp);
      apb(1'b0, event_bank_pkg::OFF_COUNT, 32'h00000000);
      chk_reg(event_bank_pkg::OFF_COUNT + 8'(4 * lane), exp);
   endtask

   task automatic arm;
      wr(event_bank_pkg::OFF_CMD, 32'h00000001);
      repeat (3) @(posedge pclk);
   endtask

   task automatic t_reset;
      chk_reg(event_bank_pkg::OFF_CTRL, 32'h00000000);
      chk_reg(event_bank_pkg::OFF_IRQ_MASK, 32'h00000000);
      chk_reg(8'hfc, 32'h00000000);
      chk(32'(last_err), 32'h00000001);
      chk({30'h0, irq, run_oe}, 32'h00000000);
   endtask

   task automatic t_edges;
      wr(event_bank_pkg::OFF_CFG + 8'h14, 32'h00000003);
      arm();
      i_src.pulse(7, 5);
      i_src.pulse(5, 3);
      repeat (6) @(posedge pclk);
      chk_cnt(7, 32'h00000005);
      chk_cnt(5, 32'h00000003);
   endtask

   task automatic t_updown;
      wr(event_bank_pkg::OFF_CFG + 8'h08, 32'h00000020);
      gate_in[2] <= 1'b1;
      i_src.pulse(2, 4);
      gate_in[2] <= 1'b0;
      repeat (4) @(posedge pclk);
      i_src.pulse(2, 1);
      repeat (6) @(posedge pclk);
      chk_cnt(2, 32'h00000003);
   endtask

   task automatic t_gates;
      wr(event_bank_pkg::OFF_CFG + 8'h0c, 32'h00000018);
      gate_in[3] <= 1'b1;
      i_src.pulse(3, 2);
      common_gate_in <= 1'b1;
      gate_in[3]     <= 1'b0;
      i_src.pulse(3, 1);
      gate_in[3] <= 1'b1;
      repeat (4) @(posedge pclk);
      i_src.pulse(3, 3);
      repeat (6) @(posedge pclk);
      chk_cnt(3, 32'h00000003);
   endtask

   task automatic t_load;
      wr(event_bank_pkg::OFF_CFG + 8'h10, 32'h00000080);
      wr(event_bank_pkg::OFF_START + 8'h10, 32'h12345678);
      i_src.load_pulse();
      repeat (6) @(posedge pclk);
      chk_cnt(4, 32'h12345678);
   endtask

   task automatic t_cascade;
      wr(event_bank_pkg::OFF_CFG, 32'h00000004);
      wr(event_bank_pkg::OFF_CFG + 8'h04, 32'h00000200);
      wr(event_bank_pkg::OFF_START, 32'hfffffffd);
      wr(event_bank_pkg::OFF_LOADCMD, 32'h00000001);
      arm();
      repeat (10) @(posedge pclk);
      wr(event_bank_pkg::OFF_CMD, 32'h00000002);
      chk_cnt(1, 32'h00000001);
   endtask

   task automatic t_preset;
      int n;
      wr(event_bank_pkg::OFF_CTRL, 32'h00000002);
      wr(event_bank_pkg::OFF_CFG, 32'h00000040);
      wr(event_bank_pkg::OFF_START, 32'hfffffffc);
      wr(event_bank_pkg::OFF_LOADCMD, 32'h00000001);
      wr(event_bank_pkg::OFF_IRQ_STAT, 32'h000001ff);
      wr(event_bank_pkg::OFF_IRQ_MASK, 32'h00000001);
      arm();
      chk(32'(run_oe), 32'h00000000);
      i_src.pulse(0, 3);
      n = 0;
      while (irq !== 1'b1 && n < 40)
      begin
         @(posedge pclk);
         n++;
      end
      chk(32'(irq), 32'h00000001);
      chk({30'h0, run_oe, carry_out[0]}, 32'h00000003);
      chk_cnt(0, 32'hffffffff);
      chk_reg(event_bank_pkg::OFF_STATUS, 32'h00000004);
      wr(event_bank_pkg::OFF_IRQ_STAT, 32'h00000001);
      repeat (2) @(posedge pclk);
      chk(32'(irq), 32'h00000000);
      wr(event_bank_pkg::OFF_IRQ_MASK, 32'h00000100);
      repeat (2) @(posedge pclk);
      chk(32'(irq), 32'h00000001);
      wr(event_bank_pkg::OFF_IRQ_STAT, 32'h000001ff);
      wr(event_bank_pkg::OFF_IRQ_MASK, 32'h00000000);
   endtask

   task automatic t_watch;
      wr(event_bank_pkg::OFF_CFG + 8'h18, 32'h00000100);
      arm();
      i_src.hold_low(1'b1);
      i_src.pulse(6, 2);
      i_src.hold_low(1'b0);
      i_src.pulse(6, 1);
      repeat (6) @(posedge pclk);
      chk_cnt(6, 32'h00000001);
      wr(event_bank_pkg::OFF_CTRL, 32'h00000001);
      arm();
      chk(32'(run_oe), 32'h00000000);
      i_src.hold_low(1'b1);
      repeat (8) @(posedge pclk);
      i_src.hold_low(1'b0);
      apb(1'b0, event_bank_pkg::OFF_STATUS, 32'h00000000);
      chk(32'(rv[0]), 32'h00000000);
      chk_reg(event_bank_pkg::OFF_IRQ_STAT, 32'h00000100);
      wr(event_bank_pkg::OFF_CTRL, 32'h00000004);
      repeat (2) @(posedge pclk);
      chk(32'(run_oe), 32'h00000001);
   endtask

   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_edges();
      t_updown();
      t_gates();
      t_load();
      t_cascade();
      t_preset();
      t_watch();
      finish_test();
   end

   initial
   begin
      #400000;
      err_total++;
      finish_test();
   end
endmodule
`default_nettype wire
